// ### logic/mac_store_pkg.sv
// Shared constants and types for the MAC and store hazard pipeline
package mac_store_pkg;
  localparam int unsigned DATA_W        = 64;
  localparam int unsigned HALF_W        = 32;
  localparam int unsigned ADDR_W        = 32;
  localparam int unsigned REG_IDX_W     = 5;
  localparam int unsigned NUM_REGS      = 32;
  localparam int unsigned MUL_STAGES    = 3;
  localparam int unsigned ADD_STAGES    = 1;
  localparam int unsigned MAC_LATENCY   = MUL_STAGES + ADD_STAGES;
  localparam int unsigned STORE_EXEC    = 3;
  localparam int unsigned MUL_EXEC      = 4;
  localparam int unsigned SQ_DEPTH      = 4;
  localparam int unsigned SQ_IDX_W      = 2;
  localparam int unsigned SQ_CNT_W      = 3;
  localparam int unsigned INTERLOCK_CYC = 2;
  localparam int unsigned PERF_W        = 32;
  localparam logic [DATA_W-1:0] ACC_RESET = 64'h0000000000000000;
  typedef enum logic {
    MAC_OVERWRITE,
    MAC_ACCUMULATE
  } mac_mode_type;
  typedef enum {
    DRAIN_IDLE,
    DRAIN_WAIT,
    DRAIN_WRITE
  } drain_state_type;
endpackage

// ### logic/mac_unit.sv
// Four-stage multiply-accumulate unit with back-to-back accumulator forwarding
`timescale 1ns/1ps
module mac_unit (
  input  wire logic                                   clk,
  input  wire logic                                   arst_n,
  input  wire logic                                   in_valid,
  input  wire mac_store_pkg::mac_mode_type            in_mode,
  input  wire logic [mac_store_pkg::HALF_W-1:0]       in_a,
  input  wire logic [mac_store_pkg::HALF_W-1:0]       in_b,
  output logic                                        out_valid,
  output logic [mac_store_pkg::DATA_W-1:0]            out_result
);
  localparam int unsigned NS = mac_store_pkg::MUL_STAGES;

  logic [NS-1:0]                        stage_valid;
  mac_store_pkg::mac_mode_type          stage_mode [NS];
  logic [mac_store_pkg::DATA_W-1:0]     stage_prod [NS];
  logic [mac_store_pkg::DATA_W-1:0]     acc;

  // Three multiply stages; product formed in stage 0, carried through the rest
  // First stage is split out so no slot ever names a stage below zero
  genvar s;
  generate
    for (s = 0; s < NS; s++) begin : g_mul
      if (s == 0) begin : g_first
        always_ff @(posedge clk or negedge arst_n) begin
          if (!arst_n) begin
            stage_valid[s] <= 1'b0;
            stage_mode[s]  <= mac_store_pkg::MAC_OVERWRITE;
            stage_prod[s]  <= '0;
          end else begin
            stage_valid[s] <= in_valid;
            stage_mode[s]  <= in_mode;
            stage_prod[s]  <= 64'(in_a) * 64'(in_b);
          end
        end
      end else begin : g_next
        always_ff @(posedge clk or negedge arst_n) begin
          if (!arst_n) begin
            stage_valid[s] <= 1'b0;
            stage_mode[s]  <= mac_store_pkg::MAC_OVERWRITE;
            stage_prod[s]  <= '0;
          end else begin
            stage_valid[s] <= stage_valid[s-1];
            stage_mode[s]  <= stage_mode[s-1];
            stage_prod[s]  <= stage_prod[s-1];
          end
        end
      end
    end
  endgenerate

  // Add stage reads the accumulator register directly, so a dependent MAC
  // one cycle behind sees the fresh sum without a bubble
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc        <= mac_store_pkg::ACC_RESET;
      out_valid  <= 1'b0;
      out_result <= '0;
    end else begin
      out_valid <= stage_valid[NS-1];
      if (stage_valid[NS-1]) begin
        if (stage_mode[NS-1] == mac_store_pkg::MAC_OVERWRITE) begin
          acc        <= stage_prod[NS-1];
          out_result <= stage_prod[NS-1];
        end else begin
          acc        <= acc + stage_prod[NS-1];
          out_result <= acc + stage_prod[NS-1];
        end
      end
    end
  end
endmodule

// ### logic/mac_and_store_hazard_pipeline.sv
// Hazard control: MAC pipe, 32/64 interlock, store completion and load replay
`timescale 1ns/1ps
module mac_and_store_hazard_pipeline (
  input  wire logic                                    clk,
  input  wire logic                                    arst_n,
  // MAC issue
  input  wire logic                                    mac_valid,
  input  wire mac_store_pkg::mac_mode_type             mac_mode,
  input  wire logic [mac_store_pkg::HALF_W-1:0]        mac_a,
  input  wire logic [mac_store_pkg::HALF_W-1:0]        mac_b,
  output logic                                         mac_done,
  output logic [mac_store_pkg::DATA_W-1:0]             mac_result,
  // Register writes and 64-bit reads for the interlock
  input  wire logic                                    wr_valid,
  input  wire logic [mac_store_pkg::REG_IDX_W-1:0]     wr_idx,
  input  wire logic                                    wr_is_64,
  input  wire logic                                    rd64_valid,
  input  wire logic [mac_store_pkg::REG_IDX_W-1:0]     rd64_idx,
  output logic                                         interlock_stall,
  // Store and multiply execution
  input  wire logic                                    st_issue,
  input  wire logic [mac_store_pkg::ADDR_W-1:0]        st_vaddr,
  input  wire logic [mac_store_pkg::REG_IDX_W-1:0]     st_data_idx,
  input  wire logic                                    mul_issue,
  output logic                                         st_exec_done,
  output logic                                         mul_exec_done,
  // Completion
  input  wire logic                                    prod_complete,
  input  wire logic [mac_store_pkg::REG_IDX_W-1:0]     prod_idx,
  input  wire logic                                    st_complete_req,
  input  wire logic [mac_store_pkg::DATA_W-1:0]        arch_rd_data,
  output logic [mac_store_pkg::REG_IDX_W-1:0]          arch_rd_idx,
  output logic                                         st_retire,
  output logic                                         st_retire_stall,
  // Cache write side
  input  wire logic                                    cache_ready,
  output logic                                         cache_wr,
  output logic [mac_store_pkg::ADDR_W-1:0]             cache_addr,
  output logic [mac_store_pkg::DATA_W-1:0]             cache_data,
  // Loads
  input  wire logic                                    ld_valid,
  input  wire logic [mac_store_pkg::ADDR_W-1:0]        ld_addr,
  output logic                                         ld_accept,
  output logic                                         ld_replay,
  output logic [mac_store_pkg::PERF_W-1:0]             replay_count
);
  localparam int unsigned D = mac_store_pkg::SQ_DEPTH;

  // Multiply-accumulate datapath
  mac_unit u_mac (
    .clk        (clk),
    .arst_n     (arst_n),
    .in_valid   (mac_valid),
    .in_mode    (mac_mode),
    .in_a       (mac_a),
    .in_b       (mac_b),
    .out_valid  (mac_done),
    .out_result (mac_result)
  );

  // Per-register flag: last writer produced only the low 32 bits
  logic [mac_store_pkg::NUM_REGS-1:0] half_written;
  logic [1:0]                         ilk_cnt;
  logic                               ilk_hit;
  assign ilk_hit = rd64_valid && half_written[rd64_idx];
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      half_written <= '0;
    end else begin
      // As soon as the interlock starts the merged value counts as whole again
      if (ilk_hit && ilk_cnt == 2'h0) begin
        half_written[rd64_idx] <= 1'b0;
      end
      if (wr_valid) begin
        half_written[wr_idx] <= !wr_is_64;
      end
    end
  end

  // Interlock holds the consumer a fixed two cycles; the flag view clears on the edge it starts
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ilk_cnt         <= '0;
      interlock_stall <= 1'b0;
    end else if (ilk_cnt != 2'h0) begin
      ilk_cnt         <= ilk_cnt - 2'h1;
      interlock_stall <= (ilk_cnt != 2'h1);
    end else if (ilk_hit) begin
      ilk_cnt         <= 2'(mac_store_pkg::INTERLOCK_CYC);
      interlock_stall <= 1'b1;
    end else begin
      interlock_stall <= 1'b0;
    end
  end

  // Execution timing: store three cycles, multiply four, run in parallel
  logic [mac_store_pkg::STORE_EXEC-2:0] st_pipe;
  logic [mac_store_pkg::MUL_EXEC-2:0]   mul_pipe;
  logic [mac_store_pkg::ADDR_W-1:0]     st_xaddr;
  logic [mac_store_pkg::REG_IDX_W-1:0]  st_xidx;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_pipe  <= '0;
      mul_pipe <= '0;
      st_xaddr <= '0;
      st_xidx  <= '0;
    end else begin
      // No data dependency checked here: store runs before its data exists
      st_pipe  <= {st_pipe[mac_store_pkg::STORE_EXEC-3:0], st_issue};
      mul_pipe <= {mul_pipe[mac_store_pkg::MUL_EXEC-3:0], mul_issue};
      if (st_issue) begin
        st_xaddr <= st_vaddr; // identity translation
        st_xidx  <= st_data_idx;
      end
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_exec_done  <= 1'b0;
      mul_exec_done <= 1'b0;
    end else begin
      st_exec_done  <= st_pipe[mac_store_pkg::STORE_EXEC-2];
      mul_exec_done <= mul_pipe[mac_store_pkg::MUL_EXEC-2];
    end
  end

  // Pending-store queue, program order, circular
  logic [mac_store_pkg::ADDR_W-1:0]   sq_addr [D];
  logic [mac_store_pkg::DATA_W-1:0]   sq_data [D];
  logic [D-1:0]                       sq_vld;
  logic [mac_store_pkg::SQ_IDX_W-1:0] sq_head;
  logic [mac_store_pkg::SQ_IDX_W-1:0] sq_tail;
  logic [mac_store_pkg::SQ_CNT_W-1:0] sq_cnt;
  logic                               sq_full;
  logic                               same_cycle_prod;
  logic                               do_retire;
  logic                               do_drain;
  logic                               rd_pending;
  logic [mac_store_pkg::ADDR_W-1:0]   rd_addr;
  assign sq_full         = (sq_cnt == mac_store_pkg::SQ_CNT_W'(D));
  assign same_cycle_prod = prod_complete && (prod_idx == st_xidx);
  assign do_retire       = st_complete_req && !same_cycle_prod && !sq_full && !rd_pending;
  assign do_drain        = cache_wr && cache_ready;

  // Retire: read register file now, enqueue data one cycle later
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      arch_rd_idx     <= '0;
      st_retire       <= 1'b0;
      st_retire_stall <= 1'b0;
      rd_pending      <= 1'b0;
      rd_addr         <= '0;
    end else begin
      st_retire       <= do_retire;
      st_retire_stall <= st_complete_req && !do_retire;
      rd_pending      <= do_retire;
      if (do_retire) begin
        arch_rd_idx <= st_xidx;
        rd_addr     <= st_xaddr;
      end
    end
  end

  // Queue storage, one generate slot per entry
  genvar e;
  generate
    for (e = 0; e < D; e++) begin : g_sq
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          sq_vld[e]  <= 1'b0;
          sq_addr[e] <= '0;
          sq_data[e] <= '0;
        end else if (rd_pending && sq_tail == mac_store_pkg::SQ_IDX_W'(e)) begin
          sq_vld[e]  <= 1'b1;
          sq_addr[e] <= rd_addr;
          sq_data[e] <= arch_rd_data;
        end else if (do_drain && sq_head == mac_store_pkg::SQ_IDX_W'(e)) begin
          sq_vld[e] <= 1'b0;
        end
      end
    end
  endgenerate

  // Pointers and occupancy
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sq_head <= '0;
      sq_tail <= '0;
      sq_cnt  <= '0;
    end else begin
      if (rd_pending) sq_tail <= sq_tail + mac_store_pkg::SQ_IDX_W'(1);
      if (do_drain) sq_head <= sq_head + mac_store_pkg::SQ_IDX_W'(1);
      sq_cnt <= sq_cnt + mac_store_pkg::SQ_CNT_W'(rd_pending)
                - mac_store_pkg::SQ_CNT_W'(do_drain);
    end
  end

  // Cache write: oldest entry only, after completion, waits on cache_ready
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cache_wr   <= 1'b0;
      cache_addr <= '0;
      cache_data <= '0;
    end else if (!cache_wr || cache_ready) begin
      // Wait for the drain to update head before offering the next entry
      cache_wr   <= sq_vld[sq_head] && !do_drain;
      cache_addr <= sq_addr[sq_head];
      cache_data <= sq_data[sq_head];
    end
  end

  // Load collision: compare against every queued store and the one in flight
  logic [D-1:0] hit_vec;
  logic         ld_hit;
  generate
    for (e = 0; e < D; e++) begin : g_cmp
      assign hit_vec[e] = sq_vld[e] && (sq_addr[e] == ld_addr);
    end
  endgenerate
  assign ld_hit = (|hit_vec) || (rd_pending && rd_addr == ld_addr);

  // Loads never take store data; a hit replays until the entry drains
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ld_accept    <= 1'b0;
      ld_replay    <= 1'b0;
      replay_count <= '0;
    end else begin
      ld_accept <= ld_valid && !ld_hit;
      ld_replay <= ld_valid && ld_hit;
      if (ld_valid && ld_hit) replay_count <= replay_count + mac_store_pkg::PERF_W'(1);
    end
  end
endmodule

// ### test/mac_store_checker_sva.sv
// Port-level assertions for the MAC and store hazard pipeline
`timescale 1ns/1ps
module mac_store_checker (
  input wire logic                                clk,
  input wire logic                                arst_n,
  input wire logic                                mac_valid,
  input wire logic                                mac_done,
  input wire logic                                wr_valid,
  input wire logic [mac_store_pkg::REG_IDX_W-1:0] wr_idx,
  input wire logic                                wr_is_64,
  input wire logic                                rd64_valid,
  input wire logic [mac_store_pkg::REG_IDX_W-1:0] rd64_idx,
  input wire logic                                interlock_stall,
  input wire logic                                st_issue,
  input wire logic [mac_store_pkg::REG_IDX_W-1:0] st_data_idx,
  input wire logic                                mul_issue,
  input wire logic                                st_exec_done,
  input wire logic                                mul_exec_done,
  input wire logic                                prod_complete,
  input wire logic [mac_store_pkg::REG_IDX_W-1:0] prod_idx,
  input wire logic                                st_complete_req,
  input wire logic                                st_retire,
  input wire logic                                st_retire_stall,
  input wire logic                                cache_ready,
  input wire logic                                cache_wr,
  input wire logic [mac_store_pkg::ADDR_W-1:0]    cache_addr,
  input wire logic [mac_store_pkg::DATA_W-1:0]    cache_data,
  input wire logic                                ld_valid,
  input wire logic                                ld_accept,
  input wire logic                                ld_replay
);
  logic [mac_store_pkg::REG_IDX_W-1:0] last_idx;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Only the newest store's data register matters, as the design keeps one
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n) last_idx <= '0;
    else if (st_issue) last_idx <= st_data_idx;
  // Stall only counts for a clean write-then-read pair, not one inside a stall
  property p_lock;
    logic [mac_store_pkg::REG_IDX_W-1:0] i;
    (wr_valid && !wr_is_64 && !interlock_stall, i = wr_idx) ##1
    (rd64_valid && rd64_idx == i && !wr_valid && !interlock_stall) |=> interlock_stall[*2];
  endproperty
  property p_nolock;
    logic [mac_store_pkg::REG_IDX_W-1:0] i;
    (wr_valid && wr_is_64 && !interlock_stall, i = wr_idx) ##1
    (rd64_valid && rd64_idx == i && !wr_valid && !interlock_stall) |=> !interlock_stall;
  endproperty
  a_mac_latency: assert property (mac_valid |-> ##4 mac_done)
    else $error("mac result late");
  a_mac_cause: assert property (mac_done |-> $past(mac_valid, 4))
    else $error("mac result without entry");
  a_chain_forward: assert property (mac_valid[*2] |-> ##3 mac_done[*2])
    else $error("dependent mac chain broken");
  a_interlock_len: assert property (p_lock)
    else $error("interlock missing");
  a_no_interlock: assert property (p_nolock)
    else $error("needless interlock");
  a_store_exec: assert property (st_issue |-> ##3 st_exec_done)
    else $error("store exec timing");
  a_mul_exec: assert property (mul_issue |-> ##4 mul_exec_done)
    else $error("multiply exec timing");
  a_no_pair_retire: assert property (st_complete_req && prod_complete && prod_idx == last_idx
    |=> !st_retire && st_retire_stall) else $error("store retired with producer");
  a_cache_hold: assert property (cache_wr && !cache_ready
    |=> cache_wr && $stable(cache_addr) && $stable(cache_data)) else $error("cache write dropped");
  a_load_answer: assert property (ld_valid |=> ld_accept ^ ld_replay)
    else $error("load not answered");
  c_chain: cover property (mac_valid[*4]);
  c_lock: cover property (p_lock);
  c_replay: cover property (ld_replay[*3]);
endmodule
bind mac_and_store_hazard_pipeline mac_store_checker u_mac_store_checker (.*);

// ### test/mac_and_store_hazard_pipeline_bench.sv
// Self-checking bench for the MAC and store hazard pipeline
`timescale 1ns/1ps
module mac_and_store_hazard_pipeline_bench;
  logic        clk = 1'b0, arst_n = 1'b0, mac_valid = 1'b0, wr_valid = 1'b0, wr_is_64 = 1'b0;
  logic        rd64_valid = 1'b0, st_issue = 1'b0, mul_issue = 1'b0, prod_complete = 1'b0;
  logic        st_complete_req = 1'b0, cache_ready = 1'b0, ld_valid = 1'b0;
  logic        mac_done, interlock_stall, st_exec_done, mul_exec_done, st_retire;
  logic        st_retire_stall, cache_wr, ld_accept, ld_replay;
  logic [31:0] mac_a = '0, mac_b = '0, st_vaddr = '0, ld_addr = '0, cache_addr, replay_count;
  logic [63:0] arch_rd_data = '0, mac_result, cache_data, acc;
  logic [4:0]  wr_idx = '0, rd64_idx = '0, st_data_idx = '0, prod_idx = '0, arch_rd_idx;
  logic [63:0] exp_q[$];
  mac_store_pkg::mac_mode_type mac_mode = mac_store_pkg::MAC_OVERWRITE;
  int          fails, check_count, cyc;
  bit          ready_rand;
  mac_and_store_hazard_pipeline u_mac_and_store_hazard_pipeline (.*);
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    check_count++;
    if (seen !== want) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic give_verdict();
    if (fails == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Predict the accumulator, then issue; the prediction waits in the queue
  task automatic mac(input mac_store_pkg::mac_mode_type m);
    logic [31:0] a;
    logic [31:0] b;
    a = $urandom;
    b = $urandom;
    acc = (m == mac_store_pkg::MAC_ACCUMULATE) ? acc + 64'(a) * 64'(b) : 64'(a) * 64'(b);
    exp_q.push_back(acc);
    mac_valid <= 1'b1;
    mac_mode <= m;
    mac_a <= a;
    mac_b <= b;
    @(posedge clk);
  endtask
  // Results are matched in order, so a skipped or extra result shows at once
  always @(negedge clk) begin
    if (mac_done === 1'b1) begin
      check(mac_result, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
    end
  end
  // Cache ready held low until ready_rand is set, then random back-pressure
  always @(posedge clk) begin
    cache_ready <= ready_rand && $urandom % 2;
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    logic [31:0] addr;
    logic [4:0]  idx;
    logic [63:0] data;
    void'($urandom(67178));
    addr = $urandom;
    idx = 5'($urandom);
    data = {$urandom, $urandom};
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    mac(mac_store_pkg::MAC_OVERWRITE);
    repeat (3) mac(mac_store_pkg::MAC_ACCUMULATE);
    mac_valid <= 1'b0;
    repeat (6) @(posedge clk);
    mac(mac_store_pkg::MAC_ACCUMULATE);
    mac(mac_store_pkg::MAC_OVERWRITE);
    mac_valid <= 1'b0;
    repeat (6) @(posedge clk);
    // Half write then full write of one register, each followed by a wide read
    for (int w = 0; w < 2; w++) begin
      wr_valid <= 1'b1;
      wr_is_64 <= w[0];
      wr_idx <= idx;
      @(posedge clk);
      wr_valid <= 1'b0;
      rd64_valid <= 1'b1;
      rd64_idx <= idx;
      @(posedge clk);
      rd64_valid <= 1'b0;
      for (int k = 0; k < 3; k++) begin
        #1 check(interlock_stall, k < 2 && !w[0]);
        @(posedge clk);
      end
    end
    // Store and its producing multiply run side by side; the store ends first
    st_issue <= 1'b1;
    mul_issue <= 1'b1;
    st_vaddr <= addr;
    st_data_idx <= idx;
    @(posedge clk);
    st_issue <= 1'b0;
    mul_issue <= 1'b0;
    for (int k = 1; k <= 4; k++) begin
      @(posedge clk);
      #1 check(st_exec_done, k == mac_store_pkg::STORE_EXEC - 1);
      check(mul_exec_done, k == mac_store_pkg::MUL_EXEC - 1);
    end
    @(posedge clk);
    prod_complete <= 1'b1;
    prod_idx <= idx;
    st_complete_req <= 1'b1;
    arch_rd_data <= data;
    @(posedge clk);
    prod_complete <= 1'b0;
    #1 check(st_retire_stall, 1);
    check(st_retire, 0);
    for (int k = 0; k < 8 && st_retire !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    check(st_retire, 1);
    check(arch_rd_idx, idx);
    st_complete_req <= 1'b0;
    // Loads to the pending address replay while the cache refuses the write
    ld_valid <= 1'b1;
    ld_addr <= addr;
    repeat (6) begin
      @(posedge clk);
      #1 check(ld_replay, 1);
    end
    ld_addr <= ~addr;
    @(posedge clk);
    #1 check(ld_accept, 1);
    ld_valid <= 1'b0;
    ready_rand = 1'b1;
    for (int k = 0; k < 50 && !(cache_wr === 1'b1 && cache_ready === 1'b1); k++) @(negedge clk);
    check(cache_wr, 1);
    check(cache_addr, addr);
    check(cache_data, data);
    @(posedge clk);
    ld_valid <= 1'b1;
    ld_addr <= addr;
    @(posedge clk);
    ld_valid <= 1'b0;
    #1 check(ld_accept, 1);
    check(replay_count, 6);
    repeat (2) @(posedge clk);
    check(64'(exp_q.size()), 0);
    give_verdict();
  end
endmodule
